//--- pkg/fed_defs.svh
// constants for the faceplate event display
`ifndef FED_DEFS_SVH
`define FED_DEFS_SVH
`define FED_CLK_HZ   125000000
`define FED_HOLD_S   3
`define FED_FLASH_MS 500
`define FED_DEB_MS   10
`define FED_FAST_MS  50
`define FED_NUM_MAX  24'sd999999
`define FED_NUM_MIN  -24'sd99999
`define FED_PCT_FULL 16'h0064
`define FED_ACCEL    8'sh0a
`define FED_PRI1     3'h1
`define FED_PRI2     3'h2
`define FED_PRI3     3'h3
`define FED_PRI4     3'h4
`define FED_PRI5     3'h5
`define FED_B_LOOP   0
`define FED_B_ACK    1
`define FED_B_DSEL   2
`define FED_B_UNITS  3
`define FED_B_AM     4
`define FED_B_PB1    5
`define FED_B_PB2    6
`define FED_NBTN     7
`endif

//--- pkg/fed_pkg.sv
// types for the faceplate event display
`default_nettype none
package fed_pkg;
   typedef enum logic [2:0] {
      FED_V_P = 3'h0, FED_V_S = 3'h1, FED_V_V = 3'h3, FED_V_X = 3'h2, FED_V_Y = 3'h6
   } fed_var_t;
   typedef enum logic [1:0] {
      FED_M_NORM = 2'h0, FED_M_UNITS = 2'h1, FED_M_SCROLL = 2'h3
   } fed_mode_t;
   function automatic fed_var_t fed_var_next(input fed_var_t v);
      unique case (v)
         FED_V_P: fed_var_next = FED_V_S;
         FED_V_S: fed_var_next = FED_V_V;
         FED_V_V: fed_var_next = FED_V_X;
         FED_V_X: fed_var_next = FED_V_Y;
         default: fed_var_next = FED_V_P;
      endcase
   endfunction
   function automatic logic [7:0] fed_sfx(input fed_var_t v);
      unique case (v)
         FED_V_P: fed_sfx = 8'h50;
         FED_V_S: fed_sfx = 8'h53;
         FED_V_V: fed_sfx = 8'h56;
         FED_V_X: fed_sfx = 8'h58;
         default: fed_sfx = 8'h59;
      endcase
   endfunction
endpackage
`default_nettype wire

//--- hw/fed_faceplate.sv
// faceplate display, event queue, buttons and knob
// Functional notes
// R1 - numeric output spans -99999 to 999999
// R2 - out-of-span values show nearest limit and flash
// R3 - alphanumeric shows loop tag, dot and variable suffix letter
// R4 - buttons and knob act on the active loop only; the code issues their pulses without regard to o_loop
// R5 - auto shows setpoint, manual shows valve
// R6 - loop button advances loop; each loop remembers its variable
// R7 - events ranked by priority 1-5, then by age
// R8 - station led lit on any event, flashes while unacknowledged
// R9 - loop led lit on loop event, flashes while unacknowledged
// R10 - priority 1 flashes bars and leds until acknowledged
// R11 - priority 2 flashes bars until the event clears
// R12 - priority 3 flashes leds until acknowledged
// R13 - priority 4 flashes leds until the event clears
// R14 - priority 5 shown only, no flash, no acknowledge
// R15 - alphanumeric alternates tag and condition while loop event unacknowledged
// R16 - acknowledge press marks condition acknowledged, stops flashing
// R17 - with all acknowledged, ack steps through loop events, wrapping
// R18 - scrolling ends after 3 s without ack press
// R19 - display-select steps P, S, V, X, Y cyclically
// R20 - units press shows units, tag returns after 3 s
// R21 - bar heights proportional to percent of range
// R22 - knob changes value, faster turning multiplies step
// R23 - buttons debounced to one press, knob quadrature decoded
`include "fed_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fed_faceplate #(
   parameter int NEV       = 8,
   parameter int LOOPS     = 4,
   parameter int SEGS      = 50,
   parameter int DEB_CYC   = `FED_DEB_MS * (`FED_CLK_HZ / 1000),
   parameter int FLASH_CYC = `FED_FLASH_MS * (`FED_CLK_HZ / 1000),
   parameter int HOLD_CYC  = `FED_HOLD_S * `FED_CLK_HZ,
   parameter int FAST_CYC  = `FED_FAST_MS * (`FED_CLK_HZ / 1000),
   localparam int LW = $clog2(LOOPS),
   localparam int EW = $clog2(NEV),
   localparam int SW = $clog2(SEGS + 1)
)(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_n,
   input  wire logic [`FED_NBTN-1:0]  i_btn,
   input  wire logic                  i_knob_a,
   input  wire logic                  i_knob_b,
   input  wire logic [LW:0]           i_nloops,
   input  wire logic                  i_am_auto,
   input  wire logic signed [23:0]    i_value,
   input  wire logic [6:0]            i_pct_s,
   input  wire logic [6:0]            i_pct_p,
   input  wire logic [6:0]            i_pct_v,
   input  wire logic [NEV-1:0]        i_evt_act,
   input  wire logic [3*NEV-1:0]      i_evt_pri,
   input  wire logic [LW*NEV-1:0]     i_evt_loop,
   output logic [LW-1:0]              o_loop,
   output fed_pkg::fed_var_t          o_var,
   output logic [7:0]                 o_suffix,
   output logic signed [23:0]         o_num,
   output logic                       o_num_flash,
   output fed_pkg::fed_mode_t         o_alpha_mode,
   output logic                       o_alpha_cond,
   output logic [EW-1:0]              o_alpha_evt,
   output logic [SW-1:0]              o_bar_s,
   output logic [SW-1:0]              o_bar_p,
   output logic [SW-1:0]              o_bar_v,
   output logic                       o_bar_blank,
   output logic                       o_led_station,
   output logic                       o_led_loop,
   output logic                       o_first_button_transfer_switch,
   output logic                       o_second_button_transfer_switch,
   output logic                       o_am_toggle,
   output logic                       o_knob_step,
   output logic signed [7:0]          o_knob_delta
);
   localparam int DW = $clog2(DEB_CYC + 1);
   localparam int FW = $clog2(FLASH_CYC + 1);
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam int GW = $clog2(FAST_CYC + 1);
   if (NEV < 2 || LOOPS < 2 || SEGS < 1 || DEB_CYC < 1 || FLASH_CYC < 1 || FAST_CYC < 1 ||
       HOLD_CYC < 1)
   begin : gen_chk
      $error("fed_faceplate: unsupported parameters");
   end

   // ----------------------------------------------------------------
   // button debounce
   // ----------------------------------------------------------------
   logic [`FED_NBTN-1:0] press;
   for (genvar g = 0; g < `FED_NBTN; g++)
   begin : gen_deb
      logic          s1_r, s2_r, d_r, d_nxt, p_r, p_nxt;
      logic [DW-1:0] c_r, c_nxt;
      always_comb
      begin
         c_nxt = '0;
         d_nxt = d_r;
         if (s2_r != d_r)
         begin
            if (c_r == DW'(DEB_CYC - 1))
               d_nxt = s2_r; // R23
            else
               c_nxt = c_r + 1'b1;
         end
         p_nxt = d_nxt & ~d_r; // R23
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n)
      begin
         if (!i_rst_n)
         begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            d_r  <= 1'b0;
            p_r  <= 1'b0;
            c_r  <= '0;
         end
         else
         begin
            s1_r <= i_btn[g];
            s2_r <= s1_r;
            d_r  <= d_nxt;
            p_r  <= p_nxt;
            c_r  <= c_nxt;
         end
      end
      assign press[g] = p_r;
   end
   // pulses straight from the debouncers, not qualified by o_loop, the active loop
   assign o_first_button_transfer_switch  = press[`FED_B_PB1]; // R4
   assign o_second_button_transfer_switch = press[`FED_B_PB2]; // R4
   assign o_am_toggle                     = press[`FED_B_AM]; // R4

   // ----------------------------------------------------------------
   // knob decode and accelerator
   // ----------------------------------------------------------------
   logic              ka1_r, ka2_r, kb1_r, kb2_r, step_nxt;
   logic [1:0]        kp_r;
   logic [GW-1:0]     gap_r, gap_nxt;
   logic signed [7:0] dl_nxt;
   logic [3:0]        tr;
   always_comb
   begin
      tr       = {kp_r, ka2_r, kb2_r};
      step_nxt = 1'b0;
      dl_nxt   = o_knob_delta;
      gap_nxt  = (gap_r == GW'(FAST_CYC)) ? gap_r : gap_r + 1'b1;
      if (tr == 4'h1 || tr == 4'h7 || tr == 4'he || tr == 4'h8 || // R23
          tr == 4'h2 || tr == 4'hb || tr == 4'hd || tr == 4'h4)
      begin
         step_nxt = 1'b1;
         gap_nxt  = '0;
         dl_nxt   = (gap_r < GW'(FAST_CYC)) ? `FED_ACCEL : 8'sh01; // R22
         if (tr == 4'h2 || tr == 4'hb || tr == 4'hd || tr == 4'h4)
            dl_nxt = -dl_nxt;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {ka1_r, ka2_r, kb1_r, kb2_r} <= 4'h0;
         kp_r         <= 2'h0;
         gap_r        <= '0;
         o_knob_step  <= 1'b0;
         o_knob_delta <= 8'sh00;
      end
      else
      begin
         ka1_r        <= i_knob_a;
         ka2_r        <= ka1_r;
         kb1_r        <= i_knob_b;
         kb2_r        <= kb1_r;
         kp_r         <= {ka2_r, kb2_r};
         gap_r        <= gap_nxt;
         o_knob_step  <= step_nxt;
         o_knob_delta <= dl_nxt;
      end
   end

   // ----------------------------------------------------------------
   // events, loop, variable and display
   // ----------------------------------------------------------------
   logic [2:0]         pri [NEV];
   logic [15:0]        st_r [NEV];
   logic [15:0]        st_nxt [NEV];
   fed_pkg::fed_var_t  var_r [LOOPS];
   fed_pkg::fed_var_t  var_nxt [LOOPS];
   logic [NEV-1:0]     unack_r, unack_nxt, actq_r, inl, ledf, barf;
   logic [15:0]        seq_r, seq_nxt;
   logic [LW-1:0]      loop_nxt;
   logic [EW-1:0]      scr_r, scr_nxt;
   logic [HW-1:0]      hc_r, hc_nxt;
   logic [FW-1:0]      fc_r, fc_nxt;
   logic               blink_r, blink_nxt, amq_r;
   fed_pkg::fed_mode_t mode_nxt;
   logic [EW:0]        lb;
   logic signed [23:0] num_nxt;

   // oldest of the highest priority among the masked slots
   function automatic logic [EW:0] fed_best(input logic [NEV-1:0] m);
      logic        f;
      logic [EW-1:0] bi;
      f  = 1'b0;
      bi = '0;
      for (int i = 0; i < NEV; i++)
         if (m[i] && (!f || pri[i] < pri[bi] ||
             (pri[i] == pri[bi] && $signed(st_r[i] - st_r[bi]) < 0))) // R7
         begin
            f  = 1'b1;
            bi = EW'(i);
         end
      fed_best = {f, bi};
   endfunction
   // next masked slot after cur, wrapping
   function automatic logic [EW-1:0] fed_after(input logic [NEV-1:0] m,
                                                input logic [EW-1:0] cur);
      logic [EW-1:0] n;
      n = cur;
      for (int k = NEV; k > 0; k--)
         if (m[(int'(cur) + k) % NEV])
            n = EW'((int'(cur) + k) % NEV);
      fed_after = n;
   endfunction
   function automatic logic [SW-1:0] fed_bar(input logic [6:0] p);
      logic [15:0] t;
      t = (16'(p) > `FED_PCT_FULL) ? `FED_PCT_FULL : 16'(p);
      fed_bar = SW'(t * 16'(SEGS) / `FED_PCT_FULL); // R21
   endfunction

   always_comb
   begin
      var_nxt  = var_r;
      st_nxt   = st_r;
      seq_nxt  = seq_r;
      mode_nxt = o_alpha_mode;
      scr_nxt  = scr_r;
      loop_nxt = o_loop;
      hc_nxt   = (hc_r == '0) ? hc_r : hc_r - 1'b1;
      fc_nxt   = fc_r + 1'b1;
      blink_nxt = blink_r;
      if (fc_r == FW'(FLASH_CYC - 1))
      begin
         fc_nxt    = '0;
         blink_nxt = ~blink_r;
      end
      for (int i = 0; i < NEV; i++)
      begin
         pri[i] = i_evt_pri[3*i +: 3];
         inl[i] = (i_evt_loop[LW*i +: LW] == o_loop);
      end
      lb = fed_best(unack_r & inl);
      for (int i = 0; i < NEV; i++)
      begin
         unack_nxt[i] = unack_r[i];
         if ((press[`FED_B_ACK] && lb[EW] && lb[EW-1:0] == EW'(i)) || // R16
             (!i_evt_act[i] && (pri[i] == `FED_PRI2 || pri[i] == `FED_PRI4))) // R11 R13
            unack_nxt[i] = 1'b0;
         if (i_evt_act[i] && !actq_r[i])
         begin
            st_nxt[i] = seq_r; // R7
            if (pri[i] != `FED_PRI5) // R14
               unack_nxt[i] = 1'b1;
         end
         ledf[i] = unack_r[i] && (pri[i] == `FED_PRI1 || pri[i] == `FED_PRI3 ||
                                  pri[i] == `FED_PRI4); // R10 R12 R13
         barf[i] = unack_r[i] && (pri[i] == `FED_PRI1 || pri[i] == `FED_PRI2); // R10 R11
      end
      if (|(i_evt_act & ~actq_r))
         seq_nxt = seq_r + 1'b1;
      if (press[`FED_B_DSEL])
         var_nxt[o_loop] = fed_pkg::fed_var_next(var_r[o_loop]); // R19
      if (i_am_auto != amq_r)
         var_nxt[o_loop] = i_am_auto ? fed_pkg::FED_V_S : fed_pkg::FED_V_V; // R5
      if (o_alpha_mode != fed_pkg::FED_M_NORM && hc_r == '0)
         mode_nxt = fed_pkg::FED_M_NORM; // R18 R20
      if (press[`FED_B_UNITS])
      begin
         mode_nxt = fed_pkg::FED_M_UNITS; // R20
         hc_nxt   = HW'(HOLD_CYC - 1);
      end
      if (press[`FED_B_ACK] && !(|unack_r) && |(i_evt_act & inl))
      begin
         scr_nxt  = (o_alpha_mode == fed_pkg::FED_M_SCROLL) ?
                    fed_after(i_evt_act & inl, scr_r) :
                    fed_after(i_evt_act & inl, EW'(NEV - 1)); // R17
         mode_nxt = fed_pkg::FED_M_SCROLL;
         hc_nxt   = HW'(HOLD_CYC - 1); // R18
      end
      if (press[`FED_B_LOOP])
      begin
         loop_nxt = ((LW + 1)'(o_loop) + 1'b1 >= i_nloops) ? '0 : o_loop + 1'b1; // R6
         mode_nxt = fed_pkg::FED_M_NORM;
      end
      num_nxt = i_value;
      if (i_value > `FED_NUM_MAX)
         num_nxt = `FED_NUM_MAX; // R1 R2
      else if (i_value < `FED_NUM_MIN)
         num_nxt = `FED_NUM_MIN; // R1 R2
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < NEV; i++)
            st_r[i] <= 16'h0000;
         for (int l = 0; l < LOOPS; l++)
            var_r[l] <= fed_pkg::FED_V_P;
         unack_r <= '0;
         actq_r  <= '0;
         seq_r   <= 16'h0000;
         scr_r   <= '0;
         hc_r    <= '0;
         fc_r    <= '0;
         blink_r <= 1'b0;
         amq_r   <= 1'b0;
         o_loop  <= '0;
         o_var   <= fed_pkg::FED_V_P;
         o_suffix <= 8'h50;
         o_alpha_mode <= fed_pkg::FED_M_NORM;
         o_alpha_cond <= 1'b0;
         o_alpha_evt  <= '0;
         o_num       <= 24'sh000000;
         o_num_flash <= 1'b0;
         o_bar_s <= '0;
         o_bar_p <= '0;
         o_bar_v <= '0;
         o_bar_blank   <= 1'b0;
         o_led_station <= 1'b0;
         o_led_loop    <= 1'b0;
      end
      else
      begin
         st_r    <= st_nxt;
         var_r   <= var_nxt;
         unack_r <= unack_nxt;
         actq_r  <= i_evt_act;
         seq_r   <= seq_nxt;
         scr_r   <= scr_nxt;
         hc_r    <= hc_nxt;
         fc_r    <= fc_nxt;
         blink_r <= blink_nxt;
         amq_r   <= i_am_auto;
         o_loop  <= loop_nxt;
         o_var   <= var_nxt[loop_nxt]; // R6
         o_suffix <= fed_pkg::fed_sfx(var_nxt[loop_nxt]); // R3
         o_alpha_mode <= mode_nxt;
         o_alpha_cond <= mode_nxt == fed_pkg::FED_M_NORM && lb[EW] && blink_r; // R15
         o_alpha_evt  <= (mode_nxt == fed_pkg::FED_M_SCROLL) ? scr_nxt : lb[EW-1:0];
         o_num       <= num_nxt;
         o_num_flash <= (num_nxt != i_value) && blink_r; // R2
         o_bar_s <= fed_bar(i_pct_s);
         o_bar_p <= fed_bar(i_pct_p);
         o_bar_v <= fed_bar(i_pct_v);
         o_bar_blank   <= (|barf) && !blink_r; // R10 R11
         o_led_station <= (|ledf) ? blink_r : |i_evt_act; // R8
         o_led_loop    <= (|(ledf & inl)) ? blink_r : |(i_evt_act & inl); // R9
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_num_clamp_hi: assert property (i_value > `FED_NUM_MAX |=> o_num == `FED_NUM_MAX) // R1
      else $error("numeric not clamped high");
   a_num_clamp_lo: assert property (i_value < `FED_NUM_MIN |=> o_num == `FED_NUM_MIN) // R2
      else $error("numeric not clamped low");
   a_suffix_match: assert property (o_suffix == fed_pkg::fed_sfx(o_var)) // R3
      else $error("suffix does not match variable");
   a_am_auto_sp: assert property ($rose(i_am_auto) && !press[`FED_B_LOOP] // R5
      |=> o_var == fed_pkg::FED_V_S)
      else $error("auto did not show setpoint");
   a_dsel_step: assert property (press[`FED_B_DSEL] && !press[`FED_B_LOOP] // R19
      && i_am_auto == amq_r |=> o_var == fed_pkg::fed_var_next($past(o_var)))
      else $error("display select did not step");
   a_loop_wrap: assert property (press[`FED_B_LOOP] // R6
      && (LW + 1)'(o_loop) + 1'b1 >= i_nloops |=> o_loop == '0)
      else $error("loop did not wrap");
   a_pri5_noack: assert property ($rose(i_evt_act[0]) && pri[0] == `FED_PRI5 // R14
      && !unack_r[0] |=> !unack_r[0])
      else $error("priority 5 awaits acknowledge");
   a_ack_clears: assert property (press[`FED_B_ACK] && lb[EW] && lb[EW-1:0] == '0 // R16
      ##0 !(i_evt_act[0] && !actq_r[0]) |=> !unack_r[0])
      else $error("acknowledge did not clear");
   a_led_idle: assert property (!(|i_evt_act) && !(|ledf) |=> !o_led_station) // R8
      else $error("station led lit with no event");
   a_scroll_tmo: assert property (o_alpha_mode == fed_pkg::FED_M_SCROLL && hc_r == '0 // R18
      && !(|press) |=> o_alpha_mode == fed_pkg::FED_M_NORM)
      else $error("scroll did not time out");
   c_scroll: cover property (o_alpha_mode == fed_pkg::FED_M_SCROLL);
   c_units: cover property (o_alpha_mode == fed_pkg::FED_M_UNITS);
   c_cond: cover property (o_alpha_cond);
   c_knob_fast: cover property (o_knob_step && o_knob_delta == `FED_ACCEL);
endmodule
`default_nettype wire

//--- verification/fed_operator.sv
// operator model: pushbuttons and pulser knob
`include "fed_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fed_operator #(
   parameter int DEB = 4
)(
   input  wire logic                  i_sys_clk,
   output logic [`FED_NBTN-1:0]       o_btn,
   output logic                       o_knob_a,
   output logic                       o_knob_b
);
   logic [1:0] ph;
   initial
   begin
      o_btn = '0;
      o_knob_a = 1'b0;
      o_knob_b = 1'b0;
      ph = 2'h0;
   end
   // one actuation: held for hold cycles, released, then a settle gap
   task automatic press(input int k, input int hold);
      @(negedge i_sys_clk);
      o_btn[k] = 1'b1;
      repeat (hold) @(negedge i_sys_clk);
      o_btn[k] = 1'b0;
      repeat (DEB + 6) @(negedge i_sys_clk);
   endtask
   // n quadrature edges, gap cycles apart; up runs 00,01,11,10 on {a,b}
   task automatic turn(input bit up, input int n, input int gap);
      repeat (n)
      begin
         repeat (gap) @(negedge i_sys_clk);
         ph = up ? ph + 2'h1 : ph - 2'h1;
         o_knob_a = ph[1];
         o_knob_b = ph[1] ^ ph[0];
      end
   endtask
endmodule
`default_nettype wire

//--- verification/faceplate_event_display_tb.sv
// testbench for the faceplate event display
`include "fed_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module faceplate_event_display_tb;
   localparam int DEB = 4;
   localparam int HLD = 40;
   localparam int FST = 16;
   localparam int SEGS = 50;
   logic                 sys_clk, rst_n, ka, kb, am_auto, num_fl, cond, bar_blank;
   logic [`FED_NBTN-1:0] btn;
   logic [2:0]           nloops, aevt;
   logic signed [23:0]   value, num;
   logic [6:0]           pct_s, pct_p, pct_v;
   logic [7:0]           ev_act, sfx;
   logic [23:0]          ev_pri;
   logic [15:0]          ev_loop;
   logic [1:0]           loop_q;
   fed_pkg::fed_var_t    var_q;
   fed_pkg::fed_mode_t   mode_q;
   logic [5:0]           bar_s, bar_p, bar_v;
   logic                 led_s, led_l, pb1, pb2, am_t, k_step;
   logic signed [7:0]    k_d_q, k_d;
   logic                 s_hi, s_lo, l_hi, b_hi, c_hi, f_hi;
   int                   failures = 0;
   int                   comparisons = 0;
   int                   cyc = 0;
   int                   k_n = 0;
   int                   p1_n = 0;
   int                   p2_n = 0;
   int                   am_n = 0;

   fed_operator #(.DEB(DEB)) u_op (.i_sys_clk(sys_clk), .o_btn(btn), .o_knob_a(ka), .o_knob_b(kb));

   fed_faceplate #(.NEV(8), .LOOPS(4), .SEGS(SEGS), .DEB_CYC(DEB), .FLASH_CYC(8),
      .HOLD_CYC(HLD), .FAST_CYC(FST)) u_dut (
      .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_btn(btn), .i_knob_a(ka), .i_knob_b(kb),
      .i_nloops(nloops), .i_am_auto(am_auto), .i_value(value), .i_pct_s(pct_s),
      .i_pct_p(pct_p), .i_pct_v(pct_v), .i_evt_act(ev_act), .i_evt_pri(ev_pri),
      .i_evt_loop(ev_loop), .o_loop(loop_q), .o_var(var_q), .o_suffix(sfx), .o_num(num),
      .o_num_flash(num_fl), .o_alpha_mode(mode_q), .o_alpha_cond(cond), .o_alpha_evt(aevt),
      .o_bar_s(bar_s), .o_bar_p(bar_p), .o_bar_v(bar_v), .o_bar_blank(bar_blank),
      .o_led_station(led_s), .o_led_loop(led_l), .o_first_button_transfer_switch(pb1),
      .o_second_button_transfer_switch(pb2), .o_am_toggle(am_t), .o_knob_step(k_step),
      .o_knob_delta(k_d_q));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // pulse counters and run ceiling
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (k_step === 1'b1)
      begin
         k_n <= k_n + 1;
         k_d <= k_d_q;
      end
      if (pb1 === 1'b1) p1_n <= p1_n + 1;
      if (pb2 === 1'b1) p2_n <= p2_n + 1;
      if (am_t === 1'b1) am_n <= am_n + 1;
      if (cyc == 12000)
      begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // collect which levels the flashing outputs took over n cycles
   task automatic watch(input int n);
      {s_hi, s_lo, l_hi, b_hi, c_hi, f_hi} = '0;
      repeat (n)
      begin
         @(negedge sys_clk);
         s_hi |= led_s;
         s_lo |= ~led_s;
         l_hi |= led_l;
         b_hi |= bar_blank;
         c_hi |= cond;
         f_hi |= num_fl;
      end
   endtask

   task automatic set_ev(input int s, input logic [2:0] p, input logic [1:0] lp, input logic a);
      @(negedge sys_clk);
      ev_pri[3*s +: 3] = p;
      ev_loop[2*s +: 2] = lp;
      ev_act[s] = a;
      tick(4);
   endtask

   task automatic ack;
      u_op.press(`FED_B_ACK, DEB + 4);
   endtask

   task automatic num_case(input logic signed [23:0] v, input logic signed [23:0] e,
                           input logic fl);
      @(negedge sys_clk);
      value = v;
      tick(3);
      watch(40);
      chk("numeric value", e, num);
      chk("numeric flash", fl, f_hi);
   endtask

   function automatic logic [31:0] bexp(input logic [6:0] p);
      bexp = ((p > 7'd100) ? 32'd100 : {25'd0, p}) * SEGS / 100;
   endfunction

   task automatic bar_case(input logic [6:0] s, input logic [6:0] p, input logic [6:0] v);
      @(negedge sys_clk);
      pct_s = s;
      pct_p = p;
      pct_v = v;
      tick(3);
      chk("bar s", bexp(s), bar_s);
      chk("bar p", bexp(p), bar_p);
      chk("bar v", bexp(v), bar_v);
   endtask

   task automatic knob_case(input bit up, input int gap, input logic signed [7:0] d);
      int k0;
      k0 = k_n;
      u_op.turn(up, 4, gap);
      tick(8);
      chk("knob steps", 4, k_n - k0);
      chk("knob delta", d, k_d);
   endtask

   task automatic btn_case;
      u_op.press(`FED_B_PB2, 2);
      u_op.press(`FED_B_PB1, DEB + 4);
      u_op.press(`FED_B_PB2, DEB + 4);
      u_op.press(`FED_B_AM, DEB + 4);
      chk("pb1 pulses", 1, p1_n);
      chk("pb2 pulses", 1, p2_n);
      chk("am pulses", 1, am_n);
   endtask

   task automatic dsel_case;
      fed_pkg::fed_var_t ev[5];
      logic [7:0]        es[5];
      ev = '{fed_pkg::FED_V_S, fed_pkg::FED_V_V, fed_pkg::FED_V_X, fed_pkg::FED_V_Y,
             fed_pkg::FED_V_P};
      es = '{8'h53, 8'h56, 8'h58, 8'h59, 8'h50};
      for (int i = 0; i < 5; i++)
      begin
         u_op.press(`FED_B_DSEL, DEB + 4);
         chk("variable", ev[i], var_q);
         chk("suffix", es[i], sfx);
      end
   endtask

   task automatic view_chk(input logic [1:0] l, input fed_pkg::fed_var_t v);
      chk("active loop", l, loop_q);
      chk("loop variable", v, var_q);
   endtask

   task automatic loop_case;
      @(negedge sys_clk);
      am_auto = 1'b1;
      tick(4);
      chk("auto variable", fed_pkg::FED_V_S, var_q);
      am_auto = 1'b0;
      tick(4);
      chk("manual variable", fed_pkg::FED_V_V, var_q);
      chk("manual suffix", 8'h56, sfx);
      u_op.press(`FED_B_LOOP, DEB + 4);
      view_chk(2'h1, fed_pkg::FED_V_P);
      u_op.press(`FED_B_DSEL, DEB + 4);
      u_op.press(`FED_B_LOOP, DEB + 4);
      view_chk(2'h0, fed_pkg::FED_V_V);
      u_op.press(`FED_B_LOOP, DEB + 4);
      view_chk(2'h1, fed_pkg::FED_V_S);
      u_op.press(`FED_B_LOOP, DEB + 4);
   endtask

   task automatic ev_case(input logic [2:0] pri, input logic [1:0] lp);
      set_ev(0, pri, lp, 1'b1);
      watch(40);
      chk("station lit", 1, s_hi);
      chk("station flash", pri == 1 || pri == 3 || pri == 4, s_lo);
      chk("loop lit", lp == 0, l_hi);
      chk("bar flash", pri <= 2, b_hi);
      chk("alpha alternate", pri != 5 && lp == 0, c_hi);
      if (pri == 1 || pri == 3)
      begin
         ack();
         watch(40);
         chk("acked steady", 0, s_lo | b_hi | c_hi);
      end
      set_ev(0, pri, lp, 1'b0);
      watch(40);
      chk("cleared", 0, s_hi | b_hi | c_hi);
   endtask

   task automatic order_case;
      set_ev(3, 3'h3, 2'h0, 1'b1);
      set_ev(6, 3'h1, 2'h0, 1'b1);
      set_ev(1, 3'h1, 2'h0, 1'b1);
      chk("best slot", 6, aevt);
      ack();
      chk("next slot", 1, aevt);
      ack();
      chk("last slot", 3, aevt);
      ack();
      @(negedge sys_clk);
      ev_act = '0;
      tick(4);
   endtask

   task automatic hold_chk(input fed_pkg::fed_mode_t m);
      tick(20);
      chk("mode held", m, mode_q);
      tick(20);
      chk("mode back", fed_pkg::FED_M_NORM, mode_q);
   endtask

   task automatic scroll_case;
      set_ev(5, 3'h5, 2'h0, 1'b1);
      set_ev(2, 3'h5, 2'h0, 1'b1);
      set_ev(4, 3'h5, 2'h1, 1'b1);
      ack();
      chk("scroll mode", fed_pkg::FED_M_SCROLL, mode_q);
      chk("scroll first", 2, aevt);
      ack();
      chk("scroll second", 5, aevt);
      ack();
      chk("scroll wrap", 2, aevt);
      hold_chk(fed_pkg::FED_M_SCROLL);
      @(negedge sys_clk);
      ev_act = '0;
      u_op.press(`FED_B_UNITS, DEB + 4);
      chk("units mode", fed_pkg::FED_M_UNITS, mode_q);
      hold_chk(fed_pkg::FED_M_UNITS);
   endtask

   initial
   begin
      rst_n = 1'b0;
      nloops = 3'h2;
      am_auto = 1'b0;
      value = 24'sh000000;
      {pct_s, pct_p, pct_v} = '0;
      {ev_act, ev_pri, ev_loop} = '0;
      tick(3);
      rst_n = 1'b1;
      tick(2);
      view_chk(2'h0, fed_pkg::FED_V_P);
      chk("reset suffix", 8'h50, sfx);
      btn_case();
      dsel_case();
      loop_case();
      num_case(24'sd1000000, 24'sd999999, 1'b1);
      num_case(24'sd999999, 24'sd999999, 1'b0);
      num_case(-24'sd100000, -24'sd99999, 1'b1);
      num_case(-24'sd99999, -24'sd99999, 1'b0);
      bar_case(7'h64, 7'h21, 7'h7f);
      bar_case(7'h00, 7'h63, 7'h01);
      knob_case(1'b1, FST + 8, 8'sh01);
      knob_case(1'b1, 2, 8'sh0a);
      knob_case(1'b0, FST + 8, -8'sh01);
      knob_case(1'b0, 2, -8'sh0a);
      ev_case(3'h1, 2'h0);
      ev_case(3'h2, 2'h0);
      ev_case(3'h3, 2'h0);
      ev_case(3'h4, 2'h0);
      ev_case(3'h5, 2'h1);
      order_case();
      scroll_case();
      print_verdict();
   end
endmodule
`default_nettype wire
